/* File: hdl/pcs_pkg.sv */
// shared constants and carrier types for the command and status pair
package pcs_pkg;
  // configuration offsets: command low half, status high half
  localparam logic [7:0]  CMD_OFF      = 8'h04;
  localparam logic [7:0]  STAT_OFF     = 8'h06;
  // command bit positions of writable enables
  localparam int          CMD_SERR     = 8;
  localparam int          CMD_PERR     = 6;
  localparam int          CMD_MWI      = 4;
  localparam int          CMD_MASTER   = 2;
  localparam int          CMD_MEM      = 1;
  localparam logic [15:0] CMD_WR_MASK  = 16'h0156;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  // status: value after reset and fixed bits (timing 01b, list bit)
  localparam logic [15:0] STAT_RESET   = 16'h0210;
  localparam logic [15:0] STAT_FIXED   = 16'h0210;
  localparam logic [1:0]  DEVSEL_MED   = 2'h1;
  // sticky status bit positions
  localparam int          ST_PAR       = 15;
  localparam int          ST_SYS       = 14;
  localparam int          ST_MABT      = 13;
  localparam int          ST_TABT_RX   = 12;
  localparam int          ST_TABT_TX   = 11;
  localparam int          ST_DPAR      = 8;
  localparam int          N_STICKY     = 6;
  // initiator bus command codes
  localparam logic [3:0]  BUS_MEM_RD   = 4'h6;
  localparam logic [3:0]  BUS_MEM_WR   = 4'h7;
  localparam logic [3:0]  BUS_MEM_WRI  = 4'hF;

  // one configuration access, dword wide with byte enables
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcs_cfg_req_t;

  // configuration answer
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pcs_cfg_rsp_t;

  // bus events reported by the transaction engine, one-cycle pulses
  typedef struct packed {
    logic addr_parity_error_detected;
    logic data_parity_error_detected;
    logic perr_as_master;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
  } pcs_event_t;
endpackage

/* File: hdl/pcs_sticky_flags.sv */
// write-one-to-clear sticky flag cells
`timescale 1ns/1ps
`default_nettype none
module pcs_sticky_flags (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // per-flag set and clear strobes
  input  wire logic [pcs_pkg::N_STICKY-1:0] set,
  input  wire logic [pcs_pkg::N_STICKY-1:0] clear,
  // flag values
  output wire logic [pcs_pkg::N_STICKY-1:0] flags
);
  // all state of this module
  typedef struct packed {
    logic [pcs_pkg::N_STICKY-1:0] flags;
  } pcs_sticky_state_t;

  pcs_sticky_state_t                 state;      // registered
  pcs_sticky_state_t                 next_state; // next value
  logic [pcs_pkg::N_STICKY-1:0]      next_bit;   // per-cell next

  // per cell: set beats clear, zero writes keep the value
  for (genvar i = 0; i < pcs_pkg::N_STICKY; i++) begin : g_cell
    assign next_bit[i] = set[i] | (state.flags[i] & ~clear[i]); // RL19 RL20
  end

  // gather next state
  always_comb begin
    next_state       = state;
    next_state.flags = next_bit;
  end

  // register, all flags clear after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

  chk_set_wins: assert property (@(posedge clk) disable iff (rst) // RL20
    (set != '0) |=> ((flags & $past(set)) == $past(set)))
    else $error("set event lost to a clear");
  chk_clear_one: assert property (@(posedge clk) disable iff (rst) // RL19
    (clear != '0) |=> ((flags & $past(clear) & ~$past(set)) == '0))
    else $error("write one failed to clear flag");
  chk_zero_keeps: assert property (@(posedge clk) disable iff (rst) // RL19
    (set == '0 && clear == '0) |=> $stable(flags))
    else $error("flag changed without cause");
endmodule
`default_nettype wire

/* File: hdl/pcs_command_status.sv */
// command and status configuration register pair with bus gating
//
// Notes on behaviour
// RL1: command 15-10, 9, 7 read zero
// RL2: snoop, special, io bits zero; no io claim
// RL3: command bit 8 gates system error drive
// RL4: command bit 6 gates parity error drive
// RL5: bit 4 picks write-invalidate over plain write
// RL6: no initiator cycles unless bit 2 set
// RL7: memory cycles claimed only while bit 1 set
// RL8: command at 04h, resets to zero
// RL9: status at 06h, resets to 0210h
// RL10: bit 15 set on any parity error
// RL11: bit 14 set when system error asserted
// RL12: bit 13 set on received master abort
// RL13: bit 12 set on received target abort
// RL14: bit 11 set on signalled target abort
// RL15: bits 10-9 read 01b, medium select timing
// RL16: bit 8 needs perr, mastership, enable
// RL17: status 7-5 and 3-0 read zero
// RL18: status bit 4 always reads one
// RL19: sticky bits clear on write one only
// RL20: hardware set beats same-cycle clear
`timescale 1ns/1ps
`default_nettype none
module pcs_command_status (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // configuration access port
  input  wire pcs_pkg::pcs_cfg_req_t CFG_REQ,
  output wire pcs_pkg::pcs_cfg_rsp_t CFG_RSP,
  // bus event reports
  input  wire pcs_pkg::pcs_event_t   BUS_EVENT,
  // initiator request from the engine
  input  wire logic                 MASTER_REQ,
  input  wire logic                 MASTER_IS_WRITE,
  output wire logic                 MASTER_GO,
  output wire logic [3:0]           MASTER_CMD,
  // target decode hits and claims
  input  wire logic                 MEM_HIT,
  input  wire logic                 IO_HIT,
  output wire logic                 MEM_CLAIM,
  output wire logic                 IO_CLAIM,
  output wire logic [1:0]           DEVSEL_TIMING,
  // open-drain error pins, low when driven
  output wire logic                 SERR_N_O,
  output wire logic                 SERR_N_OE,
  output wire logic                 PERR_N_O,
  output wire logic                 PERR_N_OE
);
  // all state of this module
  typedef struct packed {
    logic [15:0]           cmd;        // command register image
    pcs_pkg::pcs_cfg_rsp_t rsp;        // configuration answer
    logic                  serr_drive; // system error pin driven
    logic                  perr_drive; // parity error pin driven
    logic                  master_go;  // initiator cycle granted
    logic [3:0]            master_cmd; // bus command for it
    logic                  mem_claim;  // memory cycle claimed
    logic                  io_claim;   // io cycle claimed, never
    logic [1:0]            devsel;     // select timing code
  } pcs_state_t;

  pcs_state_t                       state;      // registered
  pcs_state_t                       next_state; // next value
  logic [pcs_pkg::N_STICKY-1:0]     st_set;     // sticky set strobes
  logic [pcs_pkg::N_STICKY-1:0]     st_clr;     // sticky clear strobes
  logic [pcs_pkg::N_STICKY-1:0]     st_flags;   // sticky flag values
  logic [15:0]                      status;     // status read image
  logic                             dw_hit;     // access hits dword
  logic                             wr_hit;     // write to dword
  logic                             en_serr;    // command bit 8
  logic                             en_perr;    // command bit 6
  logic                             en_mwi;     // command bit 4
  logic                             en_master;  // command bit 2
  logic                             en_mem;     // command bit 1
  logic                             serr_now;   // serr this cycle

  // command enables from the register image
  assign en_serr   = state.cmd[pcs_pkg::CMD_SERR];
  assign en_perr   = state.cmd[pcs_pkg::CMD_PERR];
  assign en_mwi    = state.cmd[pcs_pkg::CMD_MWI];
  assign en_master = state.cmd[pcs_pkg::CMD_MASTER];
  assign en_mem    = state.cmd[pcs_pkg::CMD_MEM];

  // address decode: both registers share the dword at 04h
  assign dw_hit = CFG_REQ.sel &&
                  (CFG_REQ.addr[7:2] == pcs_pkg::CMD_OFF[7:2]);
  assign wr_hit = dw_hit && CFG_REQ.wr;

  // system error only after address parity error while enabled
  assign serr_now = BUS_EVENT.addr_parity_error_detected && en_serr; // RL3

  // sticky set events, index order 15,14,13,12,11,8
  assign st_set[5] = BUS_EVENT.addr_parity_error_detected ||
                     BUS_EVENT.data_parity_error_detected;               // RL10
  assign st_set[4] = serr_now;                             // RL11
  assign st_set[3] = BUS_EVENT.master_abort;               // RL12
  assign st_set[2] = BUS_EVENT.target_abort_rx;            // RL13
  assign st_set[1] = BUS_EVENT.target_abort_tx;            // RL14
  assign st_set[0] = BUS_EVENT.perr_as_master && en_perr;  // RL16

  // clear strobes: write ones in the status byte lane
  assign st_clr[5] = wr_hit && CFG_REQ.be[3] &&
                     CFG_REQ.wdata[16+pcs_pkg::ST_PAR];      // RL19
  assign st_clr[4] = wr_hit && CFG_REQ.be[3] &&
                     CFG_REQ.wdata[16+pcs_pkg::ST_SYS];
  assign st_clr[3] = wr_hit && CFG_REQ.be[3] &&
                     CFG_REQ.wdata[16+pcs_pkg::ST_MABT];
  assign st_clr[2] = wr_hit && CFG_REQ.be[3] &&
                     CFG_REQ.wdata[16+pcs_pkg::ST_TABT_RX];
  assign st_clr[1] = wr_hit && CFG_REQ.be[3] &&
                     CFG_REQ.wdata[16+pcs_pkg::ST_TABT_TX];
  assign st_clr[0] = wr_hit && CFG_REQ.be[3] &&
                     CFG_REQ.wdata[16+pcs_pkg::ST_DPAR];

  // sticky flag cells
  pcs_sticky_flags u_flags (
    .clk   (CLOCK),
    .rst   (RST),
    .set   (st_set),
    .clear (st_clr),
    .flags (st_flags)
  );

  // status image: fixed bits plus sticky flags, rest zero
  always_comb begin
    status                      = pcs_pkg::STAT_FIXED; // RL15 RL17 RL18
    status[pcs_pkg::ST_PAR]     = st_flags[5];
    status[pcs_pkg::ST_SYS]     = st_flags[4];
    status[pcs_pkg::ST_MABT]    = st_flags[3];
    status[pcs_pkg::ST_TABT_RX] = st_flags[2];
    status[pcs_pkg::ST_TABT_TX] = st_flags[1];
    status[pcs_pkg::ST_DPAR]    = st_flags[0];
  end

  // next state of command, answer and pin drivers
  always_comb begin
    next_state = state;
    // command write per byte lane, only writable bits kept
    if (wr_hit && CFG_REQ.be[0]) begin
      next_state.cmd[7:0] = CFG_REQ.wdata[7:0] &
                            pcs_pkg::CMD_WR_MASK[7:0]; // RL1 RL2
    end
    if (wr_hit && CFG_REQ.be[1]) begin
      next_state.cmd[15:8] = CFG_REQ.wdata[15:8] &
                             pcs_pkg::CMD_WR_MASK[15:8]; // RL1
    end
    // answer one cycle after the access; read shows old value
    next_state.rsp.ack = CFG_REQ.sel;
    if (dw_hit && !CFG_REQ.wr) begin
      next_state.rsp.rdata = {status, state.cmd};
    end else begin
      next_state.rsp.rdata = '0;
    end
    // error pins driven low for one cycle when enabled
    next_state.serr_drive = serr_now;                      // RL3
    next_state.perr_drive = BUS_EVENT.data_parity_error_detected && en_perr; // RL4
    // initiator gating and command choice
    next_state.master_go = MASTER_REQ && en_master;        // RL6
    if (!MASTER_IS_WRITE) begin
      next_state.master_cmd = pcs_pkg::BUS_MEM_RD;
    end else if (en_mwi) begin
      next_state.master_cmd = pcs_pkg::BUS_MEM_WRI;        // RL5
    end else begin
      next_state.master_cmd = pcs_pkg::BUS_MEM_WR;         // RL5
    end
    // target claims: memory when enabled, io never
    next_state.mem_claim = MEM_HIT && en_mem;              // RL7
    next_state.io_claim  = 1'b0;                           // RL2
    next_state.devsel    = pcs_pkg::DEVSEL_MED;            // RL15
  end

  // register the state, command clears on reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state        <= '0;
      state.cmd    <= pcs_pkg::CMD_RESET;                   // RL8
      state.devsel <= pcs_pkg::DEVSEL_MED;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flops, error pin levels tied low
  assign CFG_RSP       = state.rsp;
  assign MASTER_GO     = state.master_go;
  assign MASTER_CMD    = state.master_cmd;
  assign MEM_CLAIM     = state.mem_claim;
  assign IO_CLAIM      = state.io_claim;
  assign DEVSEL_TIMING = state.devsel;
  assign SERR_N_O      = 1'b0;
  assign SERR_N_OE     = state.serr_drive;
  assign PERR_N_O      = 1'b0;
  assign PERR_N_OE     = state.perr_drive;

  // checks
  chk_cmd_ro_zero: assert property (@(posedge CLOCK) disable iff (RST) // RL1
    state.cmd[15:9] == '0 && !state.cmd[7])
    else $error("read-only command bits not zero");
  chk_cmd_hardwired: assert property (@(posedge CLOCK) // RL2
    disable iff (RST)
    !state.cmd[5] && !state.cmd[3] && !state.cmd[0] && !IO_CLAIM)
    else $error("hardwired command bit or io claim set");
  chk_serr_gate: assert property (@(posedge CLOCK) disable iff (RST) // RL3
    SERR_N_OE |-> $past(BUS_EVENT.addr_parity_error_detected) && $past(en_serr))
    else $error("system error driven without cause");
  chk_perr_gate: assert property (@(posedge CLOCK) disable iff (RST) // RL4
    $past(BUS_EVENT.data_parity_error_detected) |-> PERR_N_OE == $past(en_perr))
    else $error("parity error drive not gated by enable");
  chk_mwi_choice: assert property (@(posedge CLOCK) disable iff (RST) // RL5
    MASTER_REQ && MASTER_IS_WRITE |=>
      MASTER_CMD == ($past(en_mwi) ? pcs_pkg::BUS_MEM_WRI
                                   : pcs_pkg::BUS_MEM_WR))
    else $error("wrong write command chosen");
  chk_master_gate: assert property (@(posedge CLOCK) disable iff (RST) // RL6
    MASTER_GO |-> $past(MASTER_REQ) && $past(en_master))
    else $error("initiator cycle without enable");
  chk_mem_gate: assert property (@(posedge CLOCK) disable iff (RST) // RL7
    $past(MEM_HIT) && !RST |-> MEM_CLAIM == $past(en_mem))
    else $error("memory claim not gated by enable");
  chk_cmd_reset: assert property (@(posedge CLOCK) // RL8
    $past(RST) |-> state.cmd == pcs_pkg::CMD_RESET && !CFG_RSP.ack)
    else $error("command not zero after reset");
  chk_stat_reset: assert property (@(posedge CLOCK) // RL9
    $past(RST) |-> status == pcs_pkg::STAT_RESET)
    else $error("status reset value wrong");
  chk_parity_flag: assert property (@(posedge CLOCK) disable iff (RST) // RL10
    BUS_EVENT.addr_parity_error_detected || BUS_EVENT.data_parity_error_detected |=>
      status[pcs_pkg::ST_PAR])
    else $error("parity error not recorded");
  chk_sys_flag: assert property (@(posedge CLOCK) disable iff (RST) // RL11
    SERR_N_OE |-> status[pcs_pkg::ST_SYS])
    else $error("system error not recorded");
  chk_abort_flags: assert property (@(posedge CLOCK) disable iff (RST) // RL12
    BUS_EVENT.master_abort |=> status[pcs_pkg::ST_MABT])
    else $error("master abort not recorded");
  chk_tabort_rx: assert property (@(posedge CLOCK) disable iff (RST) // RL13
    BUS_EVENT.target_abort_rx |=> status[pcs_pkg::ST_TABT_RX])
    else $error("received target abort not recorded");
  chk_tabort_tx: assert property (@(posedge CLOCK) disable iff (RST) // RL14
    BUS_EVENT.target_abort_tx |=> status[pcs_pkg::ST_TABT_TX])
    else $error("signalled target abort not recorded");
  chk_devsel_code: assert property (@(posedge CLOCK) disable iff (RST) // RL15
    DEVSEL_TIMING == pcs_pkg::DEVSEL_MED && status[10:9] == 2'h1)
    else $error("select timing code wrong");
  chk_dpar_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL16
    $rose(status[pcs_pkg::ST_DPAR]) |->
      $past(BUS_EVENT.perr_as_master) && $past(en_perr))
    else $error("data parity flag set without all causes");
  chk_fixed_bits: assert property (@(posedge CLOCK) // RL17 RL18
    disable iff (RST)
    status[7:5] == 3'h0 && status[3:0] == 4'h0 && status[4])
    else $error("fixed status bits wrong");
  chk_read_path: assert property (@(posedge CLOCK) disable iff (RST) // RL19
    dw_hit && !CFG_REQ.wr |=> CFG_RSP.ack &&
      CFG_RSP.rdata == {$past(status), $past(state.cmd)})
    else $error("read answer wrong or late");

  // each sticky flag needs its own cause one cycle earlier;
  // a flag that rises on its own would report a bus error
  // that never happened, so software would chase a ghost
  chk_par_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL10
    $rose(status[pcs_pkg::ST_PAR]) |->
      $past(BUS_EVENT.addr_parity_error_detected) || $past(BUS_EVENT.data_parity_error_detected))
    else $error("parity flag set without cause");
  chk_sys_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL11
    $rose(status[pcs_pkg::ST_SYS]) |->
      $past(BUS_EVENT.addr_parity_error_detected) && $past(en_serr))
    else $error("system error flag set without cause");
  chk_mabt_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL12
    $rose(status[pcs_pkg::ST_MABT]) |-> $past(BUS_EVENT.master_abort))
    else $error("master abort flag set without cause");
  chk_trx_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL13
    $rose(status[pcs_pkg::ST_TABT_RX]) |->
      $past(BUS_EVENT.target_abort_rx))
    else $error("received abort flag set without cause");
  chk_ttx_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL14
    $rose(status[pcs_pkg::ST_TABT_TX]) |->
      $past(BUS_EVENT.target_abort_tx))
    else $error("signalled abort flag set without cause");

  // data parity flag must follow when all three causes meet
  chk_dpar_set: assert property (@(posedge CLOCK) disable iff (RST) // RL16
    BUS_EVENT.perr_as_master && en_perr |=> status[pcs_pkg::ST_DPAR])
    else $error("data parity flag missed");

  // pin drivers: enabled events must drive, nothing else may
  chk_serr_follow: assert property (@(posedge CLOCK) disable iff (RST) // RL3
    BUS_EVENT.addr_parity_error_detected && en_serr |=> SERR_N_OE)
    else $error("system error drive missed");
  chk_perr_cause: assert property (@(posedge CLOCK) disable iff (RST) // RL4
    PERR_N_OE |-> $past(BUS_EVENT.data_parity_error_detected) && $past(en_perr))
    else $error("parity error driven without cause");

  // initiator and target gating in the enabled direction
  chk_master_follow: assert property (@(posedge CLOCK) disable iff (RST) // RL6
    MASTER_REQ && en_master |=> MASTER_GO)
    else $error("enabled initiator request dropped");
  chk_read_cmd: assert property (@(posedge CLOCK) disable iff (RST) // RL5
    MASTER_REQ && !MASTER_IS_WRITE |=> MASTER_CMD == pcs_pkg::BUS_MEM_RD)
    else $error("read request got a write command");
  chk_mem_follow: assert property (@(posedge CLOCK) disable iff (RST) // RL7
    MEM_HIT && en_mem |=> MEM_CLAIM)
    else $error("enabled memory cycle not claimed");

  // command image only moves on a write to its dword
  chk_cmd_write: assert property (@(posedge CLOCK) disable iff (RST) // RL1
    wr_hit && CFG_REQ.be[0] |=> state.cmd[7:0] ==
      ($past(CFG_REQ.wdata[7:0]) & pcs_pkg::CMD_WR_MASK[7:0]))
    else $error("command low byte write wrong");
  chk_cmd_hold: assert property (@(posedge CLOCK) disable iff (RST) // RL8
    !wr_hit |=> $stable(state.cmd))
    else $error("command changed without a write");

  // other dwords answer with zero data
  chk_unmapped_read: assert property (@(posedge CLOCK) disable iff (RST) // RL8
    CFG_REQ.sel && !dw_hit |=> CFG_RSP.ack && CFG_RSP.rdata == '0)
    else $error("unmapped access answered wrongly");

  // main scenarios seen at least once

  cov_serr_event: cover property (@(posedge CLOCK) disable iff (RST)
    SERR_N_OE);
  cov_mwi_issue: cover property (@(posedge CLOCK) disable iff (RST)
    MASTER_GO && MASTER_CMD == pcs_pkg::BUS_MEM_WRI);
  cov_set_clear: cover property (@(posedge CLOCK) disable iff (RST)
    (st_set & st_clr) != '0);
  cov_mem_claim: cover property (@(posedge CLOCK) disable iff (RST)
    MEM_CLAIM);
  cov_dpar_flag: cover property (@(posedge CLOCK) disable iff (RST)
    $rose(status[pcs_pkg::ST_DPAR]));
endmodule
`default_nettype wire

/* File: tb/pcs_bus_agent.sv */
// far-side bus agent: event pulses, initiator requests and decode hits
`timescale 1ns/1ps
`default_nettype none
module pcs_bus_agent (
  // event reports and engine requests toward the block
  output var pcs_pkg::pcs_event_t bus_event,
  output var logic                master_req,
  output var logic                master_is_write,
  // address decode results
  output var logic                mem_hit,
  output var logic                io_hit
);
  // one cycle of bus activity, held until the next call
  // pulses last one cycle because every cycle gets a fresh call
  task automatic put(input pcs_pkg::pcs_event_t ev, input logic [3:0] rq);
    bus_event       = ev;
    master_req      = rq[0];
    master_is_write = rq[1];
    mem_hit         = rq[2];
    io_hit          = rq[3];
  endtask

  // quiet bus at time zero
  initial begin
    put('0, 4'h0);
  end
endmodule
`default_nettype wire

/* File: tb/tb_pci_command_status_regs.sv */
// self-checking bench for the command and status register pair
`timescale 1ns/1ps
`default_nettype none
module tb_pci_command_status_regs;
  // expected outputs for one cycle
  typedef struct packed {
    logic        ack;
    logic [31:0] rd;
    logic        go;
    logic [3:0]  mc;
    logic        chk;
    logic        claim;
    logic        serr;
    logic        perr;
  } pcs_note_t;

  logic                  clk;        // 200 MHz clock
  logic                  rst;        // synchronous reset
  pcs_pkg::pcs_cfg_req_t cfg_req;    // configuration request
  wire pcs_pkg::pcs_cfg_rsp_t cfg_rsp; // configuration answer
  pcs_pkg::pcs_event_t   bus_event;  // far-side events
  logic                  mreq;       // initiator request
  logic                  mwr;        // initiator write
  logic                  mem_hit;    // memory decode hit
  logic                  io_hit;     // io decode hit
  wire logic             go;         // initiator grant
  wire logic [3:0]       mcmd;       // initiator bus command
  wire logic             mem_claim;  // memory claim
  wire logic             io_claim;   // io claim
  wire logic [1:0]       devsel;     // select timing code
  wire logic             serr_o;     // system error level
  wire logic             serr_oe;    // system error drive
  wire logic             perr_o;     // parity error level
  wire logic             perr_oe;    // parity error drive
  logic [15:0]           cmd;        // model of command register
  logic [15:0]           stat;       // model of status register
  pcs_note_t             notes[$];   // expected results, oldest first
  int                    n_errors;   // mismatches
  int                    checks;     // comparisons
  int                    cycles;     // timeout counter
  int                    seed;       // random seed

  pcs_command_status pcs_command_status_i (
    .CLOCK(clk), .RST(rst), .CFG_REQ(cfg_req), .CFG_RSP(cfg_rsp),
    .BUS_EVENT(bus_event), .MASTER_REQ(mreq), .MASTER_IS_WRITE(mwr),
    .MASTER_GO(go), .MASTER_CMD(mcmd), .MEM_HIT(mem_hit),
    .IO_HIT(io_hit), .MEM_CLAIM(mem_claim), .IO_CLAIM(io_claim),
    .DEVSEL_TIMING(devsel), .SERR_N_O(serr_o), .SERR_N_OE(serr_oe),
    .PERR_N_O(perr_o), .PERR_N_OE(perr_oe));

  pcs_bus_agent pcs_bus_agent_i (
    .bus_event(bus_event), .master_req(mreq), .master_is_write(mwr),
    .mem_hit(mem_hit), .io_hit(io_hit));

  // clock generator
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // compare one word-sized result
  task automatic cmp_word(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compare one pin-level result
  task automatic cmp_pin(input string nm, input logic e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // hold reset three cycles with a quiet bus; outputs must read idle
  task automatic do_reset();
    #1;
    rst = 1'b1;
    cfg_req = '0;
    pcs_bus_agent_i.put('0, 4'h0);
    cmd = 16'h0000;
    stat = 16'h0210;
    repeat (3) begin
      @(posedge clk);
      notes.push_back('0);
    end
  endtask

  // drive one cycle, note the expected answer, update the model
  task automatic step(input logic s, w, input logic [7:0] a,
                      input logic [3:0] b, input logic [31:0] d,
                      input pcs_pkg::pcs_event_t e, input logic [3:0] r);
    pcs_note_t   n;
    logic        hit;
    logic [15:0] set;
    #1;
    rst = 1'b0;
    cfg_req = '{s, w, a, b, d};
    pcs_bus_agent_i.put(e, r);
    hit = s & (a[7:2] == 6'h01);
    n.ack = s;
    n.rd = (hit & !w) ? {stat, cmd} : 32'h0;
    n.go = r[0] & cmd[2];
    n.mc = !r[1] ? 4'h6 : (cmd[4] ? 4'hF : 4'h7);
    n.chk = r[0];
    n.claim = r[2] & cmd[1];
    n.serr = e.addr_parity_error_detected & cmd[8];
    n.perr = e.data_parity_error_detected & cmd[6];
    set = {e.addr_parity_error_detected | e.data_parity_error_detected, n.serr, e.master_abort,
           e.target_abort_rx, e.target_abort_tx, 2'h0,
           e.perr_as_master & cmd[6], 8'h00};
    if (hit & w & b[3]) stat = stat & ~(d[31:16] & 16'hF900);
    stat = stat | set;
    if (hit & w & b[0]) cmd[7:0] = d[7:0] & 8'h56;
    if (hit & w & b[1]) cmd[15:8] = d[15:8] & 8'h01;
    @(posedge clk);
    notes.push_back(n);
  endtask

  // watcher: checks the outputs against the oldest note each cycle
  always begin
    pcs_note_t n;
    @(posedge clk);
    #2;
    if (notes.size() > 0) begin
      n = notes.pop_front();
      cmp_pin("ack", n.ack, cfg_rsp.ack);
      if (n.ack === 1'b1) cmp_word("rdata", n.rd, cfg_rsp.rdata);
      cmp_pin("go", n.go, go);
      if (n.chk === 1'b1) cmp_word("mcmd", {28'h0, n.mc}, {28'h0, mcmd});
      cmp_pin("mem_claim", n.claim, mem_claim);
      cmp_pin("io_claim", 1'b0, io_claim);
      cmp_word("devsel", 32'h1, {30'h0, devsel});
      cmp_pin("serr_oe", n.serr, serr_oe);
      cmp_pin("perr_oe", n.perr, perr_oe);
      if (serr_oe === 1'b1) cmp_pin("serr_o", 1'b0, serr_o);
      if (perr_oe === 1'b1) cmp_pin("perr_o", 1'b0, perr_o);
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    logic [31:0] x;
    logic [31:0] y;
    rst = 1'b1;
    cfg_req = '0;
    seed = 67;
    do_reset();
    step(0, 0, 8'h00, 4'h0, 32'h0, '0, 4'h0);
    // reset values, then all ones into command and read back
    step(1, 0, 8'h04, 4'hF, 32'h0, '0, 4'h0);
    step(1, 1, 8'h04, 4'hF, 32'hFFFFFFFF, '0, 4'h0);
    step(1, 0, 8'h07, 4'hF, 32'h0, '0, 4'hF);
    // every event at once with all enables on
    step(0, 0, 8'h00, 4'h0, 32'h0, '1, 4'h7);
    step(1, 0, 8'h04, 4'hF, 32'h0, '0, 4'h5);
    // zeros keep flags and clear the command; ones with new events keep bits 15, 13-11 set, clear 14 and 8
    step(1, 1, 8'h04, 4'hF, 32'h0, '0, 4'h0);
    step(1, 1, 8'h04, 4'h8, 32'hFFFF0000, '1, 4'h0);
    step(1, 0, 8'h04, 4'hF, 32'h0, '0, 4'h0);
    step(1, 1, 8'h04, 4'h8, 32'hFFFF0000, '0, 4'h0);
    step(1, 0, 8'h04, 4'hF, 32'h0, '0, 4'h0);
    // unmapped places and enables off
    step(1, 1, 8'h00, 4'hF, 32'hFFFFFFFF, '0, 4'h0);
    step(1, 0, 8'h08, 4'hF, 32'h0, '0, 4'h0);
    step(1, 1, 8'h04, 4'h3, 32'h0, '1, 4'h7);
    step(0, 0, 8'h00, 4'h0, 32'h0, '1, 4'hF);
    // reset in mid-run restores both registers
    do_reset();
    step(0, 0, 8'h00, 4'h0, 32'h0, '0, 4'h0);
    step(1, 0, 8'h04, 4'hF, 32'h0, '0, 4'h0);
    // random traffic, mostly at the register dword, sparse events
    repeat (400) begin
      x = $random(seed);
      y = $random(seed);
      step(x[0], x[1], x[2] ? 8'h04 : x[15:8], x[7:4], y,
           pcs_pkg::pcs_event_t'(x[21:16] & x[27:22]), x[31:28]);
    end
    step(0, 0, 8'h00, 4'h0, 32'h0, '0, 4'h0);
    repeat (2) @(posedge clk);
    #3;
    end_of_test();
  end
endmodule
`default_nettype wire
